// file: shared/ptq_pkg.sv
/*
 * Shared constants and types for the pulse trigger qualifier: register map,
 * control word layout, class, polarity and condition codes, timing counts.
 * Assumes a 100 MHz core clock and a qualification tick of 13.2 ns.
 */
package ptq_pkg;

   // Core clock period and qualification tick, in picoseconds.
   localparam int CLK_PS          = 10000;
   localparam int TICK_PS         = 13200;
   // Time registers count in units of 3.3 ns so that 10 s fits in 32 bits.
   localparam int UNIT_PS         = 3300;
   localparam int UNITS_PER_TICK  = TICK_PS / UNIT_PS;
   localparam int UNIT_SHIFT      = $clog2(UNITS_PER_TICK);
   localparam int ROUND_HALF      = UNITS_PER_TICK / 2;
   localparam int LIMIT_MIN_PS    = 39600;
   localparam int LIMIT_MAX_S     = 10;
   localparam int CNT_W           = 30;
   localparam logic [CNT_W-1:0] MIN_TICKS = CNT_W'(LIMIT_MIN_PS / TICK_PS);
   localparam logic [CNT_W-1:0] MAX_TICKS =
      CNT_W'(longint'(LIMIT_MAX_S) * 64'd1000000000000 / longint'(TICK_PS));
   localparam int BAND_PCT        = 5;
   localparam int BAND_DIV        = 100 / BAND_PCT;
   // Volts per second for one millivolt across one tick.
   localparam int RATE_SCALE      = 1000000000 / TICK_PS;
   localparam int NUM_W           = 56;

   // Register byte offsets.
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_WIDTH_TIME = 8'h04;
   localparam logic [7:0] REG_RUNT_TIME  = 8'h08;
   localparam logic [7:0] REG_EDGE_INTV  = 8'h0C;
   localparam logic [7:0] REG_RUNT_HIGH  = 8'h10;
   localparam logic [7:0] REG_RUNT_LOW   = 8'h14;
   localparam logic [7:0] REG_EDGE_HIGH  = 8'h18;
   localparam logic [7:0] REG_EDGE_LOW   = 8'h1C;
   localparam logic [7:0] REG_PRESET     = 8'h20;
   localparam logic [7:0] REG_EDGE_RATE  = 8'h24;
   localparam logic [7:0] REG_STATUS     = 8'h28;
   localparam logic [7:0] REG_LAST       = 8'h2C;

   localparam logic [31:0] CTRL_RESET    = 32'h0000_2080;
   localparam logic [3:0]  PRE_RUNT_TTL  = 4'h1;
   localparam logic [3:0]  PRE_RUNT_ECL  = 4'h2;
   localparam logic [3:0]  PRE_EDGE_TTL  = 4'h4;
   localparam logic [3:0]  PRE_EDGE_ECL  = 4'h8;

   // Thresholds in signed millivolts.
   localparam logic signed [31:0] TTL_HIGH_MV = 32'sh7D0;
   localparam logic signed [31:0] TTL_LOW_MV  = 32'sh320;
   localparam logic signed [31:0] ECL_HIGH_MV = -32'sh44C;
   localparam logic signed [31:0] ECL_LOW_MV  = -32'sh5DC;

   localparam logic [1:0] CLS_WIDTH = 2'h0;
   localparam logic [1:0] CLS_RUNT  = 2'h1;
   localparam logic [1:0] CLS_EDGE  = 2'h2;

   localparam logic [1:0] POL_ANY   = 2'h0;
   localparam logic [1:0] POL_POS   = 2'h1;
   localparam logic [1:0] POL_NEG   = 2'h2;

   localparam logic [2:0] COND_ANY    = 3'h0;
   localparam logic [2:0] COND_BELOW  = 3'h1;
   localparam logic [2:0] COND_ABOVE  = 3'h2;
   localparam logic [2:0] COND_MATCH  = 3'h3;
   localparam logic [2:0] COND_DIFFER = 3'h4;

   typedef struct packed {
      logic [6:0] rsvd;
      logic       enable;
      logic [7:0] source;
      logic [2:0] edge_when;
      logic [2:0] runt_when;
      logic [2:0] width_when;
      logic [1:0] edge_pol;
      logic [1:0] runt_pol;
      logic       width_neg;
      logic [1:0] pclass;
   } ptq_ctrl_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_POS  = 3'b010,
      ST_NEG  = 3'b100
   } ptq_state_e;

endpackage : ptq_pkg

// file: verilog/ptq_tick_gen.sv
/*
 * Fractional divider: one-cycle enable on average every TICK_PS.
 * Assumes TICK_PS is larger than CLK_PS.
 */
`timescale 1ns/10ps
`default_nettype none
module ptq_tick_gen
#(
   parameter int STEP = ptq_pkg::CLK_PS,
   parameter int MODV = ptq_pkg::TICK_PS
)
(
   input  wire logic clk,
   input  wire logic rst,
   output var  logic tick
);
   logic [15:0] acc_q;
   logic [16:0] sum;

   assign sum = {1'b0, acc_q} + 17'(STEP);

   // Jitter of one clock on each tick is the price of a non-integer ratio.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc_q <= 16'h0000;
         tick  <= 1'b0;
      end
      else if (sum >= 17'(MODV))
      begin
         acc_q <= 16'(sum - 17'(MODV));
         tick  <= 1'b1;
      end
      else
      begin
         acc_q <= sum[15:0];
         tick  <= 1'b0;
      end
   end
endmodule : ptq_tick_gen
`default_nettype wire

// file: verilog/ptq_divider.sv
/*
 * Sequential restoring divider, one quotient bit per clock.
 * Assumes start is only raised while busy is low; zero divisor gives all ones.
 */
`timescale 1ns/10ps
`default_nettype none
module ptq_divider
#(
   parameter int NW = ptq_pkg::NUM_W,
   parameter int DW = 32
)
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          start,
   input  wire logic [NW-1:0] num,
   input  wire logic [DW-1:0] den,
   output var  logic          busy,
   output var  logic          done,
   output var  logic [NW-1:0] quot
);
   logic [DW:0]   rem_q;
   logic [DW:0]   rem_sh;
   logic [DW-1:0] den_q;
   logic [7:0]    cnt_q;

   assign rem_sh = {rem_q[DW-1:0], quot[NW-1]};

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         busy  <= 1'b0;
         done  <= 1'b0;
         quot  <= '0;
         rem_q <= '0;
         den_q <= '0;
         cnt_q <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            quot  <= num;
            den_q <= den;
            rem_q <= '0;
            cnt_q <= 8'(NW);
            busy  <= 1'b1;
         end
         else if (busy)
         begin
            if (rem_sh >= {1'b0, den_q})
            begin
               rem_q <= rem_sh - {1'b0, den_q};
               quot  <= {quot[NW-2:0], 1'b1};
            end
            else
            begin
               rem_q <= rem_sh;
               quot  <= {quot[NW-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 8'h01;
            if (cnt_q == 8'h01)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule : ptq_divider
`default_nettype wire

// file: verilog/ptq_qualifier.sv
/*
 * Pulse trigger qualifier: duration, runt (low-amplitude) and edge-speed classes,
 * with an Avalon-MM register slave that uses waitrequest.
 * Assumes cmp_low and cmp_high are asynchronous comparator levels that are
 * high while the source is above the low and the high threshold.
 */
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ptq_qualifier
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   input  wire logic        cmp_low,
   input  wire logic        cmp_high,
   output var  logic        trig_out
);
   import ptq_pkg::*;

   ptq_ctrl_s          ctrl_q;
   logic [CNT_W-1:0]   wtime_q;
   logic [CNT_W-1:0]   rtime_q;
   logic [CNT_W-1:0]   etime_q;
   logic [31:0]        rhigh_q;
   logic [31:0]        rlow_q;
   logic [31:0]        ehigh_q;
   logic [31:0]        elow_q;
   logic [31:0]        rate_q;
   logic [CNT_W-1:0]   last_q;
   logic [CNT_W-1:0]   cnt_q;
   logic               reached_q;
   ptq_state_e         st_q;
   logic [1:0]         lo_sync_q;
   logic [1:0]         hi_sync_q;
   logic               lo_p_q;
   logic               hi_p_q;
   logic               div_start_q;
   logic               div_to_intv_q;
   logic               tick;
   logic               div_busy;
   logic               div_done;
   logic [NUM_W-1:0]   div_quot;
   logic [NUM_W-1:0]   div_num;
   logic [31:0]        div_den;
   logic [31:0]        rd_val;
   logic [31:0]        wd;
   logic               go;
   logic               wr_go;
   logic               lo_s;
   logic               hi_s;
   logic               lo_rise;
   logic               lo_fall;
   logic               hi_rise;
   logic               hi_fall;
   logic               pos_go;
   logic               neg_go;
   logic               fin;
   logic               abort;
   logic               reach;
   logic [CNT_W-1:0]   lim_sel;
   logic [2:0]         cond_sel;

   function automatic logic [CNT_W-1:0] clamp_ticks(input logic [NUM_W-1:0] q);
      if (q < NUM_W'(MIN_TICKS))
         clamp_ticks = MIN_TICKS;
      else if (q > NUM_W'(MAX_TICKS))
         clamp_ticks = MAX_TICKS;
      else
         clamp_ticks = q[CNT_W-1:0];
   endfunction : clamp_ticks

   // Time written in 3.3 ns units becomes the nearest tick count.
   function automatic logic [CNT_W-1:0] to_ticks(input logic [31:0] t);
      logic [32:0] q;
      q = ({1'b0, t} + 33'(ROUND_HALF)) >> UNIT_SHIFT;
      to_ticks = clamp_ticks(NUM_W'(q));
   endfunction : to_ticks

   function automatic logic [31:0] from_ticks(input logic [CNT_W-1:0] n);
      from_ticks = 32'({n, {UNIT_SHIFT{1'b0}}});
   endfunction : from_ticks

   function automatic logic cond_met(input logic [CNT_W-1:0] n,
                                     input logic [CNT_W-1:0] lim,
                                     input logic [2:0]       c);
      logic [CNT_W:0] band;
      logic           in_band;
      band    = {1'b0, lim / CNT_W'(BAND_DIV)};
      in_band = ({1'b0, n} >= ({1'b0, lim} - band)) && ({1'b0, n} <= ({1'b0, lim} + band));
      unique case (c)
         COND_BELOW:  cond_met = n < lim;
         COND_ABOVE:  cond_met = n > lim;
         COND_MATCH:  cond_met = in_band;
         COND_DIFFER: cond_met = !in_band;
         default:     cond_met = 1'b1;
      endcase
   endfunction : cond_met

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be);
      for (int i = 0; i < 4; i++)
         be_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
   endfunction : be_merge

   function automatic logic pol_has_pos(input logic [1:0] p);
      pol_has_pos = (p == POL_ANY) || (p == POL_POS);
   endfunction : pol_has_pos

   function automatic logic pol_has_neg(input logic [1:0] p);
      pol_has_neg = (p == POL_ANY) || (p == POL_NEG);
   endfunction : pol_has_neg

   ptq_tick_gen u_tick
   (
      .clk  (clk),
      .rst  (rst),
      .tick (tick)
   );

   ptq_divider u_div
   (
      .clk   (clk),
      .rst   (rst),
      .start (div_start_q),
      .num   (div_num),
      .den   (div_den),
      .busy  (div_busy),
      .done  (div_done),
      .quot  (div_quot)
   );

   // Bus handshake: waitrequest drops for one cycle per accepted request.
   // Writes wait while a rate calculation runs or lands, so none is lost.
   assign go    = (avs_read || avs_write) && avs_waitrequest
                  && !(avs_write && (div_busy || div_start_q || div_done));
   assign wr_go = go && avs_write;
   assign wd    = be_merge(rd_val, avs_writedata, avs_byteenable);

   always_comb
   begin
      unique case (avs_address)
         REG_CTRL:       rd_val = ctrl_q;
         REG_WIDTH_TIME: rd_val = from_ticks(wtime_q);
         REG_RUNT_TIME:  rd_val = from_ticks(rtime_q);
         REG_EDGE_INTV:  rd_val = from_ticks(etime_q);
         REG_RUNT_HIGH:  rd_val = rhigh_q;
         REG_RUNT_LOW:   rd_val = rlow_q;
         REG_EDGE_HIGH:  rd_val = ehigh_q;
         REG_EDGE_LOW:   rd_val = elow_q;
         REG_EDGE_RATE:  rd_val = rate_q;
         REG_STATUS:     rd_val = {25'h0000000, reached_q, div_busy, hi_s, lo_s, st_q};
         REG_LAST:       rd_val = from_ticks(last_q);
         default:        rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         avs_waitrequest <= !go;
         if (go && avs_read)
            avs_readdata <= rd_val;
      end
   end

   // Configuration registers.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ctrl_q  <= CTRL_RESET;
         wtime_q <= MIN_TICKS;
         rtime_q <= MIN_TICKS;
         etime_q <= MIN_TICKS;
         rhigh_q <= TTL_HIGH_MV;
         rlow_q  <= TTL_LOW_MV;
         ehigh_q <= TTL_HIGH_MV;
         elow_q  <= TTL_LOW_MV;
      end
      else if (wr_go)
      begin
         unique case (avs_address)
            REG_CTRL:
               if (wd[1:0] != 2'h3)
                  ctrl_q <= {7'h00, wd[24:0]};
            REG_WIDTH_TIME: wtime_q <= to_ticks(wd);
            REG_RUNT_TIME:  rtime_q <= to_ticks(wd);
            REG_EDGE_INTV:  etime_q <= to_ticks(wd);
            REG_RUNT_HIGH:  rhigh_q <= wd;
            REG_RUNT_LOW:   rlow_q  <= wd;
            REG_EDGE_HIGH:  ehigh_q <= wd;
            REG_EDGE_LOW:   elow_q  <= wd;
            REG_PRESET:
            begin
               if (|(avs_writedata[3:0] & PRE_RUNT_TTL))
               begin
                  rhigh_q <= TTL_HIGH_MV;
                  rlow_q  <= TTL_LOW_MV;
               end
               else if (|(avs_writedata[3:0] & PRE_RUNT_ECL))
               begin
                  rhigh_q <= ECL_HIGH_MV;
                  rlow_q  <= ECL_LOW_MV;
               end
               if (|(avs_writedata[3:0] & PRE_EDGE_TTL))
               begin
                  ehigh_q <= TTL_HIGH_MV;
                  elow_q  <= TTL_LOW_MV;
               end
               else if (|(avs_writedata[3:0] & PRE_EDGE_ECL))
               begin
                  ehigh_q <= ECL_HIGH_MV;
                  elow_q  <= ECL_LOW_MV;
               end
            end
            default:
            begin
            end
         endcase
      end
      else if (div_done && div_to_intv_q)
         etime_q <= clamp_ticks(div_quot);
   end

   // Slew rate: any edge-speed setting change recomputes it; writing it
   // recomputes the interval from the thresholds instead.
   logic [31:0] thr_diff;
   always_comb
   begin
      thr_diff = ($signed(ehigh_q) >= $signed(elow_q)) ? ehigh_q - elow_q : elow_q - ehigh_q;
   end
   assign div_num = NUM_W'(thr_diff) * NUM_W'(RATE_SCALE);
   assign div_den = div_to_intv_q ? rate_q : 32'(etime_q);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_start_q   <= 1'b0;
         div_to_intv_q <= 1'b0;
         rate_q        <= 32'h0000_0000;
      end
      else
      begin
         div_start_q <= 1'b0;
         if (wr_go && (avs_address == REG_EDGE_RATE))
         begin
            rate_q        <= wd;
            div_to_intv_q <= 1'b1;
            div_start_q   <= 1'b1;
         end
         else if (wr_go && ((avs_address == REG_EDGE_INTV) || (avs_address == REG_EDGE_HIGH)
                  || (avs_address == REG_EDGE_LOW) || (avs_address == REG_PRESET)))
         begin
            div_to_intv_q <= 1'b0;
            div_start_q   <= 1'b1;
         end
         else if (div_done && !div_to_intv_q)
            rate_q <= (div_quot > NUM_W'(32'hFFFF_FFFF)) ? 32'hFFFF_FFFF : div_quot[31:0];
      end
   end

   // Comparator levels come from the analog front end; two stages each.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         lo_sync_q <= 2'h0;
         hi_sync_q <= 2'h0;
         lo_p_q    <= 1'b0;
         hi_p_q    <= 1'b0;
      end
      else
      begin
         lo_sync_q <= {lo_sync_q[0], cmp_low};
         hi_sync_q <= {hi_sync_q[0], cmp_high};
         lo_p_q    <= lo_sync_q[1];
         hi_p_q    <= hi_sync_q[1];
      end
   end

   assign lo_s    = lo_sync_q[1];
   assign hi_s    = hi_sync_q[1];
   assign lo_rise = lo_s && !lo_p_q;
   assign lo_fall = !lo_s && lo_p_q;
   assign hi_rise = hi_s && !hi_p_q;
   assign hi_fall = !hi_s && hi_p_q;

   // Crossing events per class; code 3 never reaches ctrl_q.
   always_comb
   begin
      pos_go   = 1'b0;
      neg_go   = 1'b0;
      fin      = 1'b0;
      abort    = 1'b0;
      reach    = 1'b0;
      lim_sel  = wtime_q;
      cond_sel = ctrl_q.width_when;
      unique case (ctrl_q.pclass)
         CLS_RUNT:
         begin
            pos_go   = lo_rise && pol_has_pos(ctrl_q.runt_pol);
            neg_go   = hi_fall && pol_has_neg(ctrl_q.runt_pol);
            reach    = (st_q == ST_POS) ? hi_rise : lo_fall;
            fin      = (st_q == ST_POS) ? lo_fall : hi_rise;
            lim_sel  = rtime_q;
            cond_sel = ctrl_q.runt_when;
         end
         CLS_EDGE:
         begin
            pos_go   = lo_rise && pol_has_pos(ctrl_q.edge_pol);
            neg_go   = hi_fall && pol_has_neg(ctrl_q.edge_pol);
            fin      = (st_q == ST_POS) ? hi_rise : lo_fall;
            abort    = (st_q == ST_POS) ? lo_fall : hi_rise;
            lim_sel  = etime_q;
            cond_sel = ctrl_q.edge_when;
         end
         default:
         begin
            pos_go = lo_rise && !ctrl_q.width_neg;
            neg_go = lo_fall && ctrl_q.width_neg;
            fin    = (st_q == ST_POS) ? lo_fall : lo_rise;
         end
      endcase
   end

   // Measurement state; a control register write restarts it.
   always_ff @(posedge clk)
   begin
      if (rst || (wr_go && avs_address == REG_CTRL))
      begin
         st_q      <= ST_IDLE;
         reached_q <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            ST_IDLE:
            begin
               reached_q <= 1'b0;
               if (pos_go)
                  st_q <= ST_POS;
               else if (neg_go)
                  st_q <= ST_NEG;
            end
            default:
            begin
               // A swing to the far threshold ends the pulse; the swing back may start one.
               if (fin || abort || reach)
                  st_q <= ST_IDLE;
               if (reach)
                  reached_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst || (st_q == ST_IDLE))
         cnt_q <= '0;
      else if (tick && (cnt_q != MAX_TICKS))
         cnt_q <= cnt_q + CNT_W'(1);
   end

   // Only the selected class decides the trigger, and only while enabled.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         trig_out <= 1'b0;
         last_q   <= '0;
      end
      else
      begin
         trig_out <= 1'b0;
         if ((st_q != ST_IDLE) && fin)
         begin
            last_q   <= cnt_q;
            trig_out <= ctrl_q.enable && cond_met(cnt_q, lim_sel, cond_sel)
                        && !((ctrl_q.pclass == CLS_RUNT) && (reached_q || reach));
         end
      end
   end

endmodule : ptq_qualifier
`default_nettype wire

// file: tb/ptq_qualifier_assertions.sv
/* Port checker for the pulse trigger qualifier.
   Assumes a bind onto ptq_qualifier; it sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module ptq_qualifier_assertions
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        cmp_low,
   input wire logic        cmp_high,
   input wire logic        trig_out
);
   import ptq_pkg::*;
   logic [7:0] quiet_q;
   logic [1:0] cmp_q;
   // The comparators pass two sync stages, so no trigger can follow a crossing at once.
   always_ff @(posedge clk)
   begin
      cmp_q <= {cmp_low, cmp_high};
      if (rst || cmp_q != {cmp_low, cmp_high})
         quiet_q <= 8'h00;
      else if (quiet_q != 8'hFF)
         quiet_q <= quiet_q + 8'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low twice in a row");
   AST_RD_ANSWER: assert property ($rose(avs_read) |=> !avs_waitrequest)
      else $error("read not answered in the next cycle");
   AST_WR_ANSWER: assert property ($rose(avs_write) |-> ##[1:100] !avs_waitrequest)
      else $error("write not answered");
   AST_RD_HOLD: assert property (avs_waitrequest && $past(avs_waitrequest)
      |-> $stable(avs_readdata)) else $error("read data moved while idle");
   AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > REG_LAST
      |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
   AST_PRESET_RD: assert property (avs_read && !avs_waitrequest && avs_address == REG_PRESET
      |-> avs_readdata == 32'h0000_0000) else $error("preset read not zero");
   AST_TRIG_PULSE: assert property (trig_out |=> !trig_out)
      else $error("trigger longer than one cycle");
   AST_TRIG_LAG: assert property (trig_out |-> quiet_q >= 8'h02)
      else $error("trigger too soon after a crossing");
endmodule : ptq_qualifier_assertions
`default_nettype wire

// file: tb/ptq_src_model.sv
/* Comparator front end and trigger counter on the far side of the qualifier.
   Assumes the bench moves the source level, in millivolts, after clock edges. */
`timescale 1ns/10ps
`default_nettype none
module ptq_src_model
#(
   parameter int HI_MV = 2000,
   parameter int LO_MV = 800
)
(
   input  wire logic clk,
   input  var  int   mv,
   input  wire logic trig,
   output var  logic cmp_low,
   output var  logic cmp_high,
   output var  int   trig_cnt
);
   // Ideal comparators without hysteresis: a level between the thresholds holds them apart.
   assign cmp_low  = mv > LO_MV;
   assign cmp_high = mv > HI_MV;
   initial trig_cnt = 0;
   always @(posedge clk)
      if (trig === 1'b1)
         trig_cnt <= trig_cnt + 1;
endmodule : ptq_src_model
`default_nettype wire

// file: tb/test_ptq_qualifier.sv
/* Bench for the pulse trigger qualifier: register and trigger checks.
   Assumes ptq_src_model drives the comparators at the reset thresholds. */
`timescale 1ns/10ps
`default_nettype none
module test_ptq_qualifier;
   import ptq_pkg::*;
   logic        clk = 0, rst = 1, rd = 0, wr = 0, cl, ch, trig, wreq;
   logic [7:0]  adr = 0;
   logic [31:0] wd = 0, rdat, q, u;
   int          mv = 0, tc, t0, e, errors = 0, num_checks = 0;
   int          wl[3] = '{66, 132, 264};
   always #5 clk = ~clk;
   ptq_src_model src_u (.clk(clk), .mv(mv), .trig(trig), .cmp_low(cl),
      .cmp_high(ch), .trig_cnt(tc));
   ptq_qualifier dut_u (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .cmp_low(cl),
      .cmp_high(ch), .trig_out(trig));
   task test_done;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x)
      begin
         errors++;
         $display("wrong value at %0t: %h, expected %h", $time, s, x);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      for (int i = 0; i <= 300; i++)
      begin
         @(posedge clk);
         if (wreq === 1'b0)
            break;
         if (i == 300)
         begin
            errors++;
            test_done;
         end
      end
      q = rdat;
      rd <= 0;
      wr <= 0;
   endtask : bus
   // A jump across both thresholds passes the middle first, so crossings never coincide.
   task automatic lv(int v, int n);
      if ((v > 2000) != (mv > 2000) && (v > 800) != (mv > 800))
         lv(1000, 3);
      mv <= v;
      repeat (n) @(posedge clk);
   endtask : lv
   function automatic int hit(int c, int t, int l);
      int d;
      d = t > l ? t - l : l - t;
      case (c)
         0: return 1;
         1: return t < l;
         2: return t > l;
         3: return d <= l / BAND_DIV;
         default: return d > l / BAND_DIV;
      endcase
   endfunction : hit
   function automatic longint tk(longint t);
      t = (t + 2) >> 2;
      return t < MIN_TICKS ? MIN_TICKS : t > MAX_TICKS ? MAX_TICKS : t;
   endfunction : tk
   initial
   begin
      t0 = $urandom(67);
      repeat (20) @(posedge clk);
      rst <= 0;
      bus(0, REG_CTRL, 0);
      chk(q, CTRL_RESET);
      bus(0, 8'h30, 0);
      chk(q, 0);
      u = $urandom_range(3000) - 1500;
      bus(1, REG_RUNT_LOW, u);
      bus(0, REG_RUNT_LOW, 0);
      chk(q, u);
      for (int a = 4; a <= 12; a += 4)
         for (int j = 0; j < 3; j++)
         begin
            u = j == 0 ? 5 : j == 1 ? 32'hD09D_C300 : $urandom_range(40000);
            bus(1, a[7:0], u);
            bus(0, a[7:0], 0);
            chk(q, 32'(4 * tk(u)));
         end
      for (int p = 3; p >= 0; p--)
      begin
         bus(1, REG_PRESET, 1 << p);
         bus(0, p > 1 ? REG_EDGE_HIGH : REG_RUNT_HIGH, 0);
         chk(q, p % 2 ? ECL_HIGH_MV : TTL_HIGH_MV);
         bus(0, p > 1 ? REG_EDGE_LOW : REG_RUNT_LOW, 0);
         chk(q, p % 2 ? ECL_LOW_MV : TTL_LOW_MV);
      end
      bus(0, REG_PRESET, 0);
      chk(q, 0);
      // A write stalls while the rate divider runs, so it marks the end of a divide.
      bus(1, REG_EDGE_INTV, 400);
      bus(1, REG_STATUS, 0);
      bus(0, REG_EDGE_RATE, 0);
      chk(q, 1200 * RATE_SCALE / 100);
      bus(1, REG_EDGE_RATE, 1200 * RATE_SCALE / 50);
      bus(1, REG_STATUS, 0);
      bus(0, REG_EDGE_INTV, 0);
      chk(q, 200);
      bus(1, REG_EDGE_INTV, 400);
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 5; c++)
         begin
            // The limit is a tick past the middle pulse, so jitter cannot decide.
            bus(1, s ? REG_RUNT_TIME : REG_WIDTH_TIME, 404);
            bus(1, REG_CTRL, 32'h0100_0000 | s | c << (7 + 3 * s));
            t0 = tc;
            e = 0;
            foreach (wl[k])
            begin
               lv(1000, wl[k]);
               lv(0, 20);
               e += hit(c, wl[k] * 100 / 132, 101);
            end
            chk(tc - t0, e);
         end
      for (int p = 0; p < 3; p++)
      begin
         bus(1, REG_CTRL, 32'h0100_0001 | p << 3);
         t0 = tc;
         lv(1000, 20);
         lv(0, 20);
         lv(3000, 20);
         lv(1000, 20);
         lv(3000, 20);
         lv(0, 20);
         chk(tc - t0, (p != 2) + (p != 1));
         bus(1, REG_CTRL, 32'h0100_2002 | p << 5);
         t0 = tc;
         foreach (wl[k])
         begin
            lv(1000, wl[k] - 56);
            lv(3000, 20);
            lv(1000, wl[k] - 56);
            lv(0, 20);
         end
         chk(tc - t0, 2 * ((p != 2) + (p != 1)));
      end
      test_done;
   end
endmodule : test_ptq_qualifier
bind ptq_qualifier ptq_qualifier_assertions chk_u (.clk(clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .cmp_low(cmp_low), .cmp_high(cmp_high), .trig_out(trig_out));
`default_nettype wire
